// ---- opguard_pkg.sv ----
/*
 Constants, register map and carrier types for the operating condition guard.
 Assumes a single 100 MHz clock domain and an AXI4-Lite master for software access.
*/
// Summary of operation
// - Any out-of-range monitored parameter except EEPROM high voltage forces a chip reset or raises an exception.
// - Voltage, frequency, temperature and light sensor alarms force a chip reset.
// - EEPROM light detector and fault injection alarms raise a CPU exception.
// - Any reset returns every register except the reset cause to its defined reset value; only power-on or reading it clears that one.
// - Software can read the cause of the most recent reset.
// - Software can read which reason triggered a monitoring exception.
// - Outside test mode all sensors are enabled automatically, no software action.
// - No register write can disable sensor monitoring.
// - Sensor to reset or exception routing is hard-wired, not software changeable.
// - Stack pointer is checked against its range; reaching a limit raises an exception.
// - Separate stack pointer and limit check copies for user, system, super system mode.
// - Software selects one of two EEPROM light detectors or none; only that one acts.
// - EEPROM high voltage is checked per write and shown only as readable status.
// - Fault detection covers PC, stack pointer, status register logic, DES, arithmetic.
// - Test mode stays permanently inaccessible once the chip is delivered.
// - The super mode flag selects super system mode and its stack pointer copy.
package opguard_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_RST_CAUSE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_EXC_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_EXC_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_EE_CTRL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_HV_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SP_LIMIT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_MODE_STAT = 8'h18;

    localparam int N_RST = 4;
    localparam int N_EXC = 8;
    localparam int SP_W = 8;
    // Exception reason bit positions
    localparam int EXC_EE_LIGHT = 0;
    localparam int EXC_FI_PC = 1;
    localparam int EXC_FI_SP = 2;
    localparam int EXC_FI_PSW = 3;
    localparam int EXC_FI_DES = 4;
    localparam int EXC_FI_ARITH = 5;
    localparam int EXC_SP_LO = 6;
    localparam int EXC_SP_HI = 7;
    localparam logic [N_EXC-1:0] EXC_MASK_RST = 8'hff;
    localparam logic [1:0] EE_SEL_RST = 2'h1;
    localparam logic [1:0] EE_SEL_OFF = 2'h0;
    localparam logic [1:0] EE_SEL_A = 2'h1;
    localparam logic [1:0] EE_SEL_B = 2'h2;
    localparam logic [SP_W-1:0] SP_LO_RST = 8'h00;
    localparam logic [SP_W-1:0] SP_HI_RST = 8'hff;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {MODE_USER, MODE_SYSTEM, MODE_SUPER} cpu_mode_t;

    typedef struct packed {
        logic voltage;
        logic frequency;
        logic temperature;
        logic light;
    } sensor_alarm_t;

    typedef struct packed {
        logic ee_light_a;
        logic ee_light_b;
        logic pc;
        logic sp;
        logic psw;
        logic des;
        logic arith;
    } fault_alarm_t;

    typedef struct packed {
        logic [SP_W-1:0] lo;
        logic [SP_W-1:0] hi;
    } sp_limit_t;

    function automatic logic [N_EXC-1:0] set_sticky(input logic [N_EXC-1:0] cur,
                                                    input logic [N_EXC-1:0] ev,
                                                    input logic clr);
        set_sticky = (clr ? '0 : cur) | ev;
    endfunction : set_sticky
endpackage : opguard_pkg

// ---- sp_limit_check.sv ----
/*
 One stack pointer limit checker, instantiated once per CPU mode.
 Assumes the stack pointer and limits are synchronous to clk.
*/
`timescale 1ns/1ns
module sp_limit_check
    import opguard_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic active,
    input wire logic [SP_W-1:0] sp,
    input wire sp_limit_t lim,
    output logic hit_lo,
    output logic hit_hi
);
    // Limit reached counts as a hit, not only overstepping it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hit_lo <= 1'b0;
            hit_hi <= 1'b0;
        end else begin
            hit_lo <= active && (sp <= lim.lo);
            hit_hi <= active && (sp >= lim.hi);
        end
    end
endmodule : sp_limit_check

// ---- reset_cause_keep.sv ----
/*
 Reset cause indicator that survives the sensor reset it records.
 Assumes por_n is a separate power-on reset that is not driven by sensor alarms.
*/
`timescale 1ns/1ns
module reset_cause_keep
    import opguard_pkg::*;
(
    input wire logic clk,
    input wire logic por_n,
    input wire sensor_alarm_t alarm,
    input wire logic clr,
    output logic [N_RST-1:0] cause_q
);
    // Only power-on or a read clears it, so software sees the cause after restart
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            cause_q <= '0;
        end else if (|alarm) begin
            cause_q <= alarm;
        end else if (clr) begin
            cause_q <= '0;
        end
    end
endmodule : reset_cause_keep

// ---- operating_condition_guard.sv ----
/*
 Operating condition guard: routes sensor alarms to chip reset and fault alarms to a CPU
 exception, records the causes, and checks the stack pointer per CPU mode.
 Assumes all alarm inputs are synchronous to clk and that chip_reset_req restarts the chip.
*/
`timescale 1ns/1ns
module operating_condition_guard
    import opguard_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic por_n,
    input wire sensor_alarm_t sensor_alarm,
    input wire fault_alarm_t fault_alarm,
    input wire logic super_mode_flag,
    input wire logic user_mode,
    input wire logic test_mode_req,
    input wire logic delivered_fuse,
    input wire logic [SP_W-1:0] sp_user,
    input wire logic [SP_W-1:0] sp_system,
    input wire logic [SP_W-1:0] sp_super,
    input wire logic ee_write_active,
    input wire logic ee_hv_ok,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic chip_reset_req,
    output logic exc_irq,
    output logic sensors_enabled,
    output logic test_mode_active
);
    logic [N_EXC-1:0] exc_stat_q;
    logic [N_EXC-1:0] exc_mask_q;
    logic [1:0] ee_sel_q;
    logic hv_fail_q;
    logic hv_done_q;
    sp_limit_t lim_q [3];
    cpu_mode_t mode;
    logic [N_RST-1:0] rst_cause;
    logic [N_EXC-1:0] exc_ev;
    logic [2:0] hit_lo;
    logic [2:0] hit_hi;
    logic ee_hit;
    sensor_alarm_t sens_eff;

    // Write channel holding registers
    logic aw_full_q;
    logic w_full_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic rd_fire;
    logic rd_clr_exc;
    logic rd_clr_rst;

    // Mode selection: the super mode flag wins over user/system
    always_comb begin
        if (super_mode_flag) begin
            mode = MODE_SUPER;
        end else if (user_mode) begin
            mode = MODE_USER;
        end else begin
            mode = MODE_SYSTEM;
        end
    end

    // Test mode blocked for good once the delivery fuse is blown
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            test_mode_active <= 1'b0;
        end else begin
            test_mode_active <= test_mode_req && !delivered_fuse;
        end
    end

    // No register bit feeds this, so software cannot turn sensors off
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sensors_enabled <= 1'b0;
        end else begin
            sensors_enabled <= !test_mode_active;
        end
    end

    assign sens_eff = sensors_enabled ? sensor_alarm : '0;

    // Hard-wired routing to reset; there is no routing register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chip_reset_req <= 1'b0;
        end else begin
            chip_reset_req <= |sens_eff;
        end
    end

    reset_cause_keep u_cause (
        .clk(clk),
        .por_n(por_n),
        .alarm(sens_eff),
        .clr(rd_clr_rst),
        .cause_q(rst_cause)
    );

    genvar gi;
    for (gi = 0; gi < 3; gi++) begin : g_sp
        logic [SP_W-1:0] sp_sel;
        assign sp_sel = (gi == 0) ? sp_user : ((gi == 1) ? sp_system : sp_super);
        sp_limit_check u_chk (
            .clk(clk),
            .arst_n(arst_n),
            .active(mode == cpu_mode_t'(gi)),
            .sp(sp_sel),
            .lim(lim_q[gi]),
            .hit_lo(hit_lo[gi]),
            .hit_hi(hit_hi[gi])
        );
    end

    // Only the selected EEPROM light detector is heeded
    always_comb begin
        case (ee_sel_q)
            EE_SEL_A: ee_hit = fault_alarm.ee_light_a;
            EE_SEL_B: ee_hit = fault_alarm.ee_light_b;
            default: ee_hit = 1'b0;
        endcase
    end

    always_comb begin
        exc_ev = '0;
        exc_ev[EXC_EE_LIGHT] = ee_hit;
        exc_ev[EXC_FI_PC] = fault_alarm.pc;
        exc_ev[EXC_FI_SP] = fault_alarm.sp;
        exc_ev[EXC_FI_PSW] = fault_alarm.psw;
        exc_ev[EXC_FI_DES] = fault_alarm.des;
        exc_ev[EXC_FI_ARITH] = fault_alarm.arith;
        exc_ev[EXC_SP_LO] = |hit_lo;
        exc_ev[EXC_SP_HI] = |hit_hi;
    end

    // Sticky reasons; a new event in the clearing cycle still lands
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            exc_stat_q <= '0;
        end else begin
            exc_stat_q <= set_sticky(exc_stat_q, exc_ev, rd_clr_exc);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            exc_irq <= 1'b0;
        end else begin
            exc_irq <= |(exc_stat_q & exc_mask_q);
        end
    end

    // High voltage check result, collected over each write sequence; done flag set at its end
    logic ee_wr_d1_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ee_wr_d1_q <= 1'b0;
            hv_fail_q <= 1'b0;
            hv_done_q <= 1'b0;
        end else begin
            ee_wr_d1_q <= ee_write_active;
            if (ee_write_active && !ee_wr_d1_q) begin
                // A bad level in the first cycle of a short write must not be lost
                hv_fail_q <= !ee_hv_ok;
                hv_done_q <= 1'b0;
            end else if (ee_write_active && !ee_hv_ok) begin
                hv_fail_q <= 1'b1;
            end else if (!ee_write_active && ee_wr_d1_q) begin
                hv_done_q <= 1'b1;
            end
        end
    end

    // AXI4-Lite write: address and data taken independently
    assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_full_q && !(s_axi_awvalid && s_axi_awready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_full_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
        end
    end

    // Writable registers: mask, detector select, stack limits; nothing reaches sensors
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            exc_mask_q <= EXC_MASK_RST;
            ee_sel_q <= EE_SEL_RST;
            for (int i = 0; i < 3; i++) begin
                lim_q[i] <= '{lo: SP_LO_RST, hi: SP_HI_RST};
            end
        end else if (wr_fire && w_strb_q[0]) begin
            if (aw_addr_q == OFS_EXC_MASK) begin
                exc_mask_q <= w_data_q[N_EXC-1:0];
            end else if (aw_addr_q == OFS_EE_CTRL) begin
                ee_sel_q <= w_data_q[1:0];
            end else if (aw_addr_q == OFS_SP_LIMIT) begin
                lim_q[mode] <= '{lo: w_data_q[SP_W-1:0], hi: w_data_q[2*SP_W-1:SP_W]};
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_q == OFS_EXC_MASK || aw_addr_q == OFS_EE_CTRL
                    || aw_addr_q == OFS_SP_LIMIT) begin
                s_axi_bresp <= AXI_OKAY;
            end else if (aw_addr_q == OFS_RST_CAUSE || aw_addr_q == OFS_EXC_STAT
                    || aw_addr_q == OFS_HV_STAT || aw_addr_q == OFS_MODE_STAT) begin
                s_axi_bresp <= AXI_OKAY;
            end else begin
                s_axi_bresp <= AXI_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read; reading the exception status or reset cause register clears it
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_clr_exc = rd_fire && (s_axi_araddr == OFS_EXC_STAT);
    assign rd_clr_rst = rd_fire && (s_axi_araddr == OFS_RST_CAUSE);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= AXI_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= AXI_OKAY;
                s_axi_rdata <= '0;
                if (s_axi_araddr == OFS_RST_CAUSE) begin
                    s_axi_rdata[N_RST-1:0] <= rst_cause;
                end else if (s_axi_araddr == OFS_EXC_STAT) begin
                    s_axi_rdata[N_EXC-1:0] <= exc_stat_q;
                end else if (s_axi_araddr == OFS_EXC_MASK) begin
                    s_axi_rdata[N_EXC-1:0] <= exc_mask_q;
                end else if (s_axi_araddr == OFS_EE_CTRL) begin
                    s_axi_rdata[1:0] <= ee_sel_q;
                end else if (s_axi_araddr == OFS_HV_STAT) begin
                    s_axi_rdata[1:0] <= {hv_done_q, hv_fail_q};
                end else if (s_axi_araddr == OFS_SP_LIMIT) begin
                    s_axi_rdata[2*SP_W-1:0] <= {lim_q[mode].hi, lim_q[mode].lo};
                end else if (s_axi_araddr == OFS_MODE_STAT) begin
                    s_axi_rdata[3:0] <= {test_mode_active, sensors_enabled, mode};
                end else begin
                    s_axi_rresp <= AXI_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    AST_SENSOR_RESET: assert property (@(posedge clk) disable iff (!arst_n)
        |sens_eff |=> chip_reset_req)
        else $error("sensor alarm did not request reset");
    AST_NO_FAULT_RESET: assert property (@(posedge clk) disable iff (!arst_n)
        (!(|sens_eff) && |fault_alarm) |=> !chip_reset_req)
        else $error("fault alarm requested reset");
    AST_FAULT_STICKY: assert property (@(posedge clk) disable iff (!arst_n)
        fault_alarm.pc |=> exc_stat_q[EXC_FI_PC])
        else $error("pc fault not recorded");
    AST_REASON_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
        (exc_stat_q[EXC_FI_DES] && !rd_clr_exc) |=> exc_stat_q[EXC_FI_DES])
        else $error("exception reason lost without read");
    AST_IRQ_FOLLOWS: assert property (@(posedge clk) disable iff (!arst_n)
        |(exc_stat_q & exc_mask_q) |=> exc_irq)
        else $error("unmasked reason without interrupt");
    AST_EE_OFF: assert property (@(posedge clk) disable iff (!arst_n)
        (ee_sel_q == EE_SEL_OFF && !exc_stat_q[EXC_EE_LIGHT])
        |=> !exc_stat_q[EXC_EE_LIGHT])
        else $error("disabled eeprom detector raised a reason");
    AST_TEST_LOCK: assert property (@(posedge clk) disable iff (!arst_n)
        delivered_fuse |=> !test_mode_active)
        else $error("test mode after delivery");
    AST_SENSORS_ON: assert property (@(posedge clk) disable iff (!arst_n)
        !test_mode_active ##1 !test_mode_active |=> sensors_enabled)
        else $error("sensors off outside test mode");
    AST_SP_LIMIT: assert property (@(posedge clk) disable iff (!arst_n)
        (mode == MODE_USER && sp_user >= lim_q[MODE_USER].hi) ##1 1'b1
        |=> exc_stat_q[EXC_SP_HI])
        else $error("stack limit not flagged");
    AST_CAUSE_KEPT: assert property (@(posedge clk) disable iff (!arst_n)
        sensor_alarm.voltage && sensors_enabled |=> rst_cause[N_RST-1])
        else $error("reset cause not recorded");

    COV_RESET: cover property (@(posedge clk) disable iff (!arst_n) chip_reset_req);
    COV_EXC: cover property (@(posedge clk) disable iff (!arst_n) $rose(exc_irq));
    COV_RD_CLR: cover property (@(posedge clk) disable iff (!arst_n) rd_clr_exc);
endmodule : operating_condition_guard

// ---- cpu_core_model.sv ----
/*
 Model of the CPU side: an AXI4-Lite master that issues one access at a time.
 Assumes the slave answers on its registered ready, bvalid and rvalid outputs.
*/
`timescale 1ns/1ns
module cpu_core_model
    import opguard_pkg::*;
(
    input wire logic clk,
    output logic [ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hf;
    end

    task automatic write_word(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                              output logic [1:0] resp);
        logic aw_open;
        logic w_open;
        aw_open = 1'b1;
        w_open = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_open || w_open) begin
            @(posedge clk);
            if (aw_open && awready === 1'b1) begin
                aw_open = 1'b0;
                awvalid <= 1'b0;
                // Released lines must not keep showing the last value
                awaddr <= ~a;
            end
            if (w_open && wready === 1'b1) begin
                w_open = 1'b0;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : write_word

    task automatic read_word(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                             output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        araddr <= ~a;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : read_word
endmodule : cpu_core_model

// ---- operating_condition_guard_bench.sv ----
/*
 Self-checking bench for the operating condition guard.
 Assumes the bench itself plays the chip reset that chip_reset_req asks for.
*/
`timescale 1ns/1ns
module operating_condition_guard_bench
    import opguard_pkg::*;
;
    logic clk, arst_n, por_n, super_mode_flag, user_mode, test_mode_req, delivered_fuse;
    logic ee_write_active, ee_hv_ok, chip_reset_req, exc_irq, sensors_enabled, test_mode_active;
    sensor_alarm_t sensor_alarm;
    fault_alarm_t fault_alarm;
    logic [SP_W-1:0] sp_user, sp_system, sp_super;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int err_count = 0;
    int checks_done = 0;

    always #5 clk = ~clk;

    operating_condition_guard dut_u (.clk, .arst_n, .por_n, .sensor_alarm, .fault_alarm,
        .super_mode_flag, .user_mode, .test_mode_req, .delivered_fuse, .sp_user, .sp_system,
        .sp_super, .ee_write_active, .ee_hv_ok, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chip_reset_req,
        .exc_irq, .sensors_enabled, .test_mode_active);

    cpu_core_model cpu_u (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        cpu_u.read_word(a, d, r);
        check(d, exp);
        check(32'(r), 32'(AXI_OKAY));
    endtask : rd_chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [1:0] r;
        cpu_u.write_word(a, d, r);
        check(32'(r), 32'(AXI_OKAY));
    endtask : wr

    task automatic pulse_fault(input logic [6:0] v);
        fault_alarm <= fault_alarm_t'(v);
        @(posedge clk);
        fault_alarm <= '0;
        repeat (3) @(posedge clk);
    endtask : pulse_fault

    task automatic chip_reset();
        arst_n <= 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : chip_reset

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd_chk(OFS_RST_CAUSE, 32'h0);
        rd_chk(OFS_EXC_MASK, 32'(EXC_MASK_RST));
        rd_chk(OFS_EE_CTRL, 32'(EE_SEL_RST));
        rd_chk(OFS_SP_LIMIT, {16'h0, SP_HI_RST, SP_LO_RST});
        cpu_u.read_word(8'h40, d, r);
        check(d, 32'h0);
        check(32'(r), 32'(AXI_SLVERR));
        cpu_u.write_word(8'h40, 32'h0, r);
        check(32'(r), 32'(AXI_SLVERR));
        wr(OFS_MODE_STAT, 32'h0);
        rd_chk(OFS_MODE_STAT, 32'h4);
        check(sensors_enabled, 1'b1);
        $display("register test done");
    endtask : t_regs

    task automatic t_sensor();
        for (int i = 0; i < N_RST; i++) begin
            sensor_alarm <= sensor_alarm_t'(4'(1 << i));
            @(posedge clk);
            sensor_alarm <= '0;
            @(posedge clk);
            check(chip_reset_req, 1'b1);
            check(exc_irq, 1'b0);
            chip_reset();
            rd_chk(OFS_RST_CAUSE, 32'(1 << i));
            rd_chk(OFS_RST_CAUSE, 32'h0);
        end
        $display("sensor reset test done");
    endtask : t_sensor

    task automatic t_faults();
        // Fault bit j (arith upward) lands on status bit 5 - j
        for (int j = 0; j < 5; j++) begin
            pulse_fault(7'(1 << j));
            check(exc_irq, 1'b1);
            check(chip_reset_req, 1'b0);
            rd_chk(OFS_EXC_STAT, 32'(1 << (5 - j)));
        end
        for (int s = 0; s < 3; s++) begin
            wr(OFS_EE_CTRL, 32'(s));
            pulse_fault(7'h40);
            rd_chk(OFS_EXC_STAT, 32'(s == 1));
            pulse_fault(7'h20);
            rd_chk(OFS_EXC_STAT, 32'(s == 2));
        end
        pulse_fault(7'h10);
        pulse_fault(7'h02);
        wr(OFS_EXC_MASK, 32'h0);
        repeat (3) @(posedge clk);
        check(exc_irq, 1'b0);
        wr(OFS_EXC_MASK, 32'hff);
        repeat (3) @(posedge clk);
        check(exc_irq, 1'b1);
        rd_chk(OFS_EXC_STAT, 32'h12);
        repeat (3) @(posedge clk);
        check(exc_irq, 1'b0);
        $display("exception test done");
    endtask : t_faults

    task automatic t_stack();
        wr(OFS_SP_LIMIT, 32'h0000f010);
        rd_chk(OFS_SP_LIMIT, 32'h0000f010);
        sp_user <= 8'hf0;
        repeat (4) @(posedge clk);
        check(exc_irq, 1'b1);
        sp_user <= 8'h10;
        repeat (4) @(posedge clk);
        sp_user <= 8'h80;
        repeat (4) @(posedge clk);
        rd_chk(OFS_EXC_STAT, 32'hc0);
        super_mode_flag <= 1'b1;
        sp_user <= 8'hf0;
        repeat (4) @(posedge clk);
        rd_chk(OFS_MODE_STAT, 32'h6);
        rd_chk(OFS_SP_LIMIT, {16'h0, SP_HI_RST, SP_LO_RST});
        rd_chk(OFS_EXC_STAT, 32'h0);
        sp_super <= 8'hff;
        repeat (4) @(posedge clk);
        sp_super <= 8'h80;
        repeat (4) @(posedge clk);
        rd_chk(OFS_EXC_STAT, 32'h80);
        super_mode_flag <= 1'b0;
        sp_user <= 8'h80;
        user_mode <= 1'b0;
        repeat (2) @(posedge clk);
        rd_chk(OFS_MODE_STAT, 32'h5);
        rd_chk(OFS_SP_LIMIT, {16'h0, SP_HI_RST, SP_LO_RST});
        user_mode <= 1'b1;
        $display("stack limit test done");
    endtask : t_stack

    task automatic t_misc();
        ee_write_active <= 1'b1;
        ee_hv_ok <= 1'b0;
        repeat (3) @(posedge clk);
        ee_write_active <= 1'b0;
        ee_hv_ok <= 1'b1;
        repeat (3) @(posedge clk);
        check({chip_reset_req, exc_irq}, 2'b00);
        rd_chk(OFS_HV_STAT, 32'h3);
        test_mode_req <= 1'b1;
        repeat (3) @(posedge clk);
        check({test_mode_active, sensors_enabled}, 2'b01);
        delivered_fuse <= 1'b0;
        repeat (3) @(posedge clk);
        check({test_mode_active, sensors_enabled}, 2'b10);
        test_mode_req <= 1'b0;
        delivered_fuse <= 1'b1;
        repeat (3) @(posedge clk);
        check(sensors_enabled, 1'b1);
        $display("voltage and mode test done");
    endtask : t_misc

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("[FAIL] %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        {clk, arst_n, por_n, super_mode_flag, test_mode_req, ee_write_active} = '0;
        {user_mode, delivered_fuse, ee_hv_ok} = 3'b111;
        {sensor_alarm, fault_alarm} = '0;
        {sp_user, sp_system, sp_super} = {3{8'h80}};
        repeat (10) @(posedge clk);
        por_n <= 1'b1;
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_sensor();
        t_faults();
        t_stack();
        t_misc();
        print_verdict();
    end
endmodule : operating_condition_guard_bench
